// File: verilog/idm_ctrl.v
/*
 * gate on/off decision for the power switch: operational diode emulation
 * (variant option) and overheat diode emulation.
 * assumes all inputs are synchronous to clk; drain sense flags arrive from
 * analog comparators and are re-registered here.
 */
// Notes on behaviour
// - command fall in state 5 enters state 1: switch off, wait positive drain
// - state 2 keeps switch off, waits negative drain, then goes to state 3
// - operational machine starts in state 2 after reset and overheat exit
// - state 3 turns switch on, stays until command rises or forward current
// - forward current in state 3 goes to state 4, locked off until rise
// - command rise moves any operational state to state 5, switch on
// - switch turned on at most once per command cycle by assist
// - operational machine only with build parameter; overheat machine always
// - overheat: any command fall forces state 1, off for blank, then state 2
// - overheat state 2 holds switch off, negative drain goes to state 3
// - overheat machine starts in state 2 on entering shutdown
// - overheat state 3 switch on, forward current returns to state 2
// - overheat state 1 leaves on blank time alone, no positive drain needed
// - without command activity overheat cycles only between states 2 and 3
// - overheat never counts or blocks repeated forward current events
// - die over-temperature hands switch control to overheat machine
// - driver over-temperature keeps switch off and suspends overheat machine
`timescale 1ns/1ps
`include "idm_ctrl_map.vh"

module idm_ctrl #(
    parameter HAS_OP_EMUL = 1,
    parameter BLANK_CYC   = (`IDM_BLANK_NS + `IDM_CLK_NS - 1) / `IDM_CLK_NS
) (
    input  wire       clk,
    input  wire       rst_n,
    input  wire       switchCmd,
    input  wire       drainPos,
    input  wire       drainNeg,
    input  wire       fwdCurrent,
    input  wire       dieOverTemp,
    input  wire       drvOverTemp,
    output reg        gateOn,
    output wire [2:0] opState,
    output wire [1:0] ohState
);

    // ****************************************************************
    // input registers
    // ****************************************************************
    reg        cmd_r;
    reg        cmdPrev_r;
    reg        pos_r;
    reg        neg_r;
    reg        fwd_r;
    reg        dieOt_r;
    reg        drvOt_r;
    reg        dieOtPrev_r;
    reg        drvOtPrev_r;

    // no metastability stage: the pins are taken as synchronous to clk
    // sense flags are registered once so both machines see one value
    always @(posedge clk) begin
        if (!rst_n) begin
            cmd_r       <= 1'b0;
            cmdPrev_r   <= 1'b0;
            pos_r       <= 1'b0;
            neg_r       <= 1'b0;
            fwd_r       <= 1'b0;
            dieOt_r     <= 1'b0;
            drvOt_r     <= 1'b0;
            dieOtPrev_r <= 1'b0;
            drvOtPrev_r <= 1'b0;
        end else begin
            cmd_r       <= switchCmd;
            cmdPrev_r   <= cmd_r;
            pos_r       <= drainPos;
            neg_r       <= drainNeg;
            fwd_r       <= fwdCurrent;
            dieOt_r     <= dieOverTemp;
            drvOt_r     <= drvOverTemp;
            dieOtPrev_r <= dieOt_r;
            drvOtPrev_r <= drvOt_r;
        end
    end

    // command edges come from the registered copy and its delayed twin; a
    // command pulse shorter than one clock can be missed entirely
    wire cmdRise = cmd_r & ~cmdPrev_r;
    wire cmdFall = ~cmd_r & cmdPrev_r;
    // overheat machine restarts at entry and when driver shutdown clears
    wire ohStart = (dieOt_r & ~dieOtPrev_r) | (dieOt_r & drvOtPrev_r & ~drvOt_r);
    // leaving die shutdown parks the op machine in state 2 for one more cycle
    wire ohExit  = ~dieOt_r & dieOtPrev_r;

    // ****************************************************************
    // operational machine
    // ****************************************************************
    // die over-temperature wins over every command edge: the overheat machine owns
    // the switch then, and this machine waits in state 2 for a fresh cycle
    reg [2:0] opState_r;
    reg [2:0] opState_nxt;

    always @* begin
        opState_nxt = opState_r;
        if (dieOt_r || ohExit) begin
            opState_nxt = `IDM_OP_WAITNEG;
        end else if (cmdRise) begin
            opState_nxt = `IDM_OP_CMDON;
        end else begin
            case (opState_r)
                `IDM_OP_CMDON: begin
                    if (cmdFall)
                        opState_nxt = `IDM_OP_WAITPOS;
                end
                `IDM_OP_WAITPOS: begin
                    if (pos_r)
                        opState_nxt = `IDM_OP_WAITNEG;
                end
                `IDM_OP_WAITNEG: begin
                    if (neg_r)
                        opState_nxt = `IDM_OP_ASSIST;
                end
                `IDM_OP_ASSIST: begin
                    if (fwd_r)
                        opState_nxt = `IDM_OP_LOCKOFF;
                end
                // lock holds until rise; only one assist per cycle
                `IDM_OP_LOCKOFF: opState_nxt = `IDM_OP_LOCKOFF;
                default: opState_nxt = `IDM_OP_WAITNEG;
            endcase
        end
    end

    always @(posedge clk) begin
        if (!rst_n)
            opState_r <= `IDM_OP_WAITNEG;
        else
            opState_r <= opState_nxt;
    end

    // ****************************************************************
    // overheat machine with blank timer
    // ****************************************************************
    // the countdown is 16 bits wide; blank times beyond 65535 cycles do not fit
    reg [1:0]  ohState_r;
    reg [1:0]  ohState_nxt;
    reg [15:0] blank_r;
    reg [15:0] blank_nxt;

    always @* begin
        ohState_nxt = ohState_r;
        blank_nxt   = blank_r;
        if (!dieOt_r || drvOt_r || ohStart) begin
            // suspended in driver shutdown; restart at state 2 on entry
            ohState_nxt = `IDM_OH_WAITNEG;
            blank_nxt   = 16'h0000;
        end else if (cmdFall) begin
            ohState_nxt = `IDM_OH_BLANK;
            blank_nxt   = BLANK_CYC[15:0];
        end else begin
            case (ohState_r)
                `IDM_OH_BLANK: begin
                    // leaves on time alone so it cannot stick
                    if (blank_r <= 16'h0001)
                        ohState_nxt = `IDM_OH_WAITNEG;
                    else
                        blank_nxt = blank_r - 16'h0001;
                end
                `IDM_OH_WAITNEG: begin
                    if (neg_r)
                        ohState_nxt = `IDM_OH_CONDUCT;
                end
                `IDM_OH_CONDUCT: begin
                    // no event counter: repeated trips are allowed
                    if (fwd_r)
                        ohState_nxt = `IDM_OH_WAITNEG;
                end
                default: ohState_nxt = `IDM_OH_WAITNEG;
            endcase
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            ohState_r <= `IDM_OH_WAITNEG;
            blank_r   <= 16'h0000;
        end else begin
            ohState_r <= ohState_nxt;
            blank_r   <= blank_nxt;
        end
    end

    // ****************************************************************
    // gate decision
    // ****************************************************************
    // the gate is decoded from the next states so it moves on the same edge as
    // the state outputs, with no extra cycle of lag on turn-on or turn-off
    reg gate_nxt;

    // with no operational machine the command drives the gate directly
    always @* begin
        if (drvOt_r)
            gate_nxt = 1'b0;
        else if (dieOt_r)
            gate_nxt = (ohState_nxt == `IDM_OH_CONDUCT);
        else if (HAS_OP_EMUL != 0)
            gate_nxt = (opState_nxt == `IDM_OP_CMDON) ||
                       (opState_nxt == `IDM_OP_ASSIST);
        else
            gate_nxt = cmd_r;
    end

    always @(posedge clk) begin
        if (!rst_n)
            gateOn <= 1'b0;
        else
            gateOn <= gate_nxt;
    end

    assign opState = opState_r;
    assign ohState = ohState_r;

endmodule

// File: verilog/idm_ctrl_map.vh
/*
 * constants for the diode-emulation gate control: state codes and blank time.
 * assumes inclusion by the control module only.
 */
`ifndef IDM_CTRL_MAP_VH
`define IDM_CTRL_MAP_VH

// operational machine states
`define IDM_OP_WAITPOS   3'h1
`define IDM_OP_WAITNEG   3'h2
`define IDM_OP_ASSIST    3'h3
`define IDM_OP_LOCKOFF   3'h4
`define IDM_OP_CMDON     3'h5

// overheat machine states
`define IDM_OH_BLANK     2'h1
`define IDM_OH_WAITNEG   2'h2
`define IDM_OH_CONDUCT   2'h3

// fixed falling-edge blank time in ns and clock period in ns
`define IDM_BLANK_NS     200
`define IDM_CLK_NS       25

`endif

// File: bench/idm_ctrl_properties.sv
/* port checker for the diode-emulation gate control.
   assumes a bind from the bench top, one clock and a synchronous reset. */
`timescale 1ns/1ps
module idm_ctrl_properties #(
    parameter BLANK_CYC = 8,
    parameter HAS_OP    = 1
) (
    input wire       clk,
    input wire       rst_n,
    input wire       switchCmd,
    input wire       drainPos,
    input wire       drainNeg,
    input wire       fwdCurrent,
    input wire       dieOverTemp,
    input wire       drvOverTemp,
    input wire       gateOn,
    input wire [2:0] opState,
    input wire [1:0] ohState
);
    // ****************************************
    // properties
    // ****************************************
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    reg [7:0] blankCnt_r;
    // length of the blank dwell; a stuck countdown shows up as an overrun
    always @(posedge clk) blankCnt_r <= (ohState == 2'h1) ? blankCnt_r + 8'h01 : 8'h00;
    a_reset_states: assert property (
        $rose(rst_n) |-> opState == 3'h2 && ohState == 2'h2 && !gateOn)
        else $error("bad state after reset");
    a_rise_to_five: assert property (
        $rose(switchCmd) && !dieOverTemp && !drvOverTemp |-> ##[1:2] opState == 3'h5)
        else $error("rise missed");
    a_fall_to_one: assert property (
        $fell(switchCmd) && opState == 3'h5 && !dieOverTemp |-> ##[1:2] opState == 3'h1)
        else $error("fall missed");
    // the gate lags both shutdown flags by two edges, hence the history terms
    a_gate_follows_op: assert property (
        HAS_OP != 0 && !dieOverTemp && !drvOverTemp && !$past(dieOverTemp)
        && !$past(dieOverTemp, 2) && !$past(drvOverTemp, 2)
        |-> gateOn == (opState == 3'h5 || opState == 3'h3))
        else $error("gate vs op state");
    // without the op machine the gate is the command, two edges late
    a_plain_gate_cmd: assert property (
        HAS_OP == 0 && !$past(dieOverTemp, 2) && !$past(drvOverTemp, 2)
        |-> gateOn == $past(switchCmd, 2))
        else $error("plain gate vs command");
    a_lock_no_assist: assert property (opState == 3'h4 |=> opState != 3'h3) else $error("second assist");
    a_blank_gate_off: assert property (ohState == 2'h1 |-> !gateOn) else $error("gate on in blank");
    a_blank_len_max: assert property (blankCnt_r <= BLANK_CYC) else $error("blank too long");
    a_conduct_gate_on: assert property (ohState == 2'h3 |-> gateOn) else $error("gate off in conduct");
    a_drv_gate_off: assert property (drvOverTemp && $past(drvOverTemp) && $past(drvOverTemp, 2) |-> !gateOn) else $error("gate on in driver shutdown");
    c_lockout: cover property (opState == 3'h4);
    c_conduct: cover property (ohState == 2'h3);
    c_blank: cover property (ohState == 2'h1);
endmodule

// File: bench/idm_cmd_src.sv
/* model of the supply controller that drives the switching command.
   assumes the bench sets the wanted level; one clock. */
`timescale 1ns/1ps
module idm_cmd_src (
    input  wire clk,
    input  wire wantOn,
    output reg  switchCmd
);
    // ****************************************
    // command timer
    // ****************************************
    reg wantOn_r;
    initial switchCmd = 1'b0;
    // the wish is taken at the rising edge, away from the bench's falling-edge
    // writes, so the output moves one cycle behind it with no race
    always @(posedge clk) wantOn_r <= wantOn;
    always @(negedge clk) switchCmd <= wantOn_r;
endmodule

// File: bench/idm_ctrl_tb.sv
/* directed bench for the diode-emulation gate control.
   assumes the checker and command model files are compiled first. */
`timescale 1ns/1ps
module idm_ctrl_tb;
    // ****************************************
    // harness
    // ****************************************
    localparam BLANK = 4;
    reg        clk, rst_n, wantOn, drainPos, drainNeg, fwdCurrent, dieOverTemp, drvOverTemp;
    wire       switchCmd, gateOn, gateOnPlain;
    wire [2:0] opState;
    wire [1:0] ohState;
    integer    mismatches, num_checks, cyc;
    // variant without the op machine, fed the same stimulus
    idm_ctrl #(.HAS_OP_EMUL(0), .BLANK_CYC(BLANK)) u_idm_ctrl_plain (.clk(clk),
        .rst_n(rst_n), .switchCmd(switchCmd), .drainPos(drainPos), .drainNeg(drainNeg),
        .fwdCurrent(fwdCurrent), .dieOverTemp(dieOverTemp), .drvOverTemp(drvOverTemp),
        .gateOn(gateOnPlain), .opState(), .ohState());
    idm_ctrl #(.HAS_OP_EMUL(1), .BLANK_CYC(BLANK)) u_idm_ctrl (.clk(clk), .rst_n(rst_n),
        .switchCmd(switchCmd), .drainPos(drainPos), .drainNeg(drainNeg),
        .fwdCurrent(fwdCurrent), .dieOverTemp(dieOverTemp), .drvOverTemp(drvOverTemp),
        .gateOn(gateOn), .opState(opState), .ohState(ohState));
    idm_cmd_src u_idm_cmd_src (.clk(clk), .wantOn(wantOn), .switchCmd(switchCmd));
    task chk(input [2:0] seen, input [2:0] exp, input [63:0] nm); begin
        num_checks = num_checks + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("Error %0s expected %0d seen %0d", nm, exp, seen);
        end
    end endtask
    // four edges cover the command model delay plus the two-stage input path
    task go; begin repeat (4) @(posedge clk); @(negedge clk); end endtask
    task report_and_stop; begin
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    end endtask
    // ****************************************
    // scenarios
    // ****************************************
    task t_op; begin
        wantOn = 1; go; chk(opState, 5, "op"); chk(gateOn, 1, "gate");
        chk(gateOnPlain, 1, "plain");
        wantOn = 0; drainNeg = 1; go; chk(opState, 1, "op"); chk(gateOn, 0, "gate");
        drainNeg = 0; drainPos = 1; go; chk(opState, 2, "op");
        drainPos = 0; drainNeg = 1; go; chk(opState, 3, "op"); chk(gateOn, 1, "gate");
        chk(gateOnPlain, 0, "plain");
        drainNeg = 0; fwdCurrent = 1; go; chk(opState, 4, "op"); chk(gateOn, 0, "gate");
        fwdCurrent = 0; drainNeg = 1; go; chk(opState, 4, "op"); chk(gateOn, 0, "gate");
        drainNeg = 0; wantOn = 1; go; chk(opState, 5, "op");
    end endtask
    task t_heat; begin
        wantOn = 0; go; chk(opState, 1, "op");
        dieOverTemp = 1; go; chk(ohState, 2, "oh"); chk(gateOn, 0, "gate");
        drainNeg = 1; go; chk(ohState, 3, "oh"); chk(gateOn, 1, "gate");
        fwdCurrent = 1; go; chk(ohState, 2, "oh"); chk(gateOn, 0, "gate");
        fwdCurrent = 0; go; chk(ohState, 3, "oh");
        drainNeg = 0; wantOn = 1; go; // switched first so the device passes its blank
        wantOn = 0; go; chk(ohState, 1, "oh"); chk(gateOn, 0, "gate");
        go; chk(ohState, 2, "oh");
        drainNeg = 1; drvOverTemp = 1; go; chk(gateOn, 0, "gate");
        drvOverTemp = 0; go; chk(ohState, 3, "oh"); chk(gateOn, 1, "gate");
        drainNeg = 0; dieOverTemp = 0; go; chk(opState, 2, "op");
    end endtask
    // ****************************************
    // main sequence and timeout
    // ****************************************
    initial begin clk = 0; forever #12.5 clk = ~clk; end
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 400) begin mismatches = mismatches + 1; report_and_stop; end
    end
    initial begin
        {rst_n, wantOn, drainPos, drainNeg, fwdCurrent, dieOverTemp, drvOverTemp} = 7'h00;
        mismatches = 0; num_checks = 0; cyc = 0;
        repeat (20) @(negedge clk);
        rst_n = 1;
        chk(opState, 2, "op"); chk(ohState, 2, "oh"); chk(gateOn, 0, "gate");
        t_op;
        t_heat;
        report_and_stop;
    end
endmodule
bind idm_ctrl idm_ctrl_properties #(.BLANK_CYC(BLANK_CYC), .HAS_OP(HAS_OP_EMUL))
    u_idm_ctrl_properties (.clk(clk),
    .rst_n(rst_n), .switchCmd(switchCmd), .drainPos(drainPos), .drainNeg(drainNeg),
    .fwdCurrent(fwdCurrent), .dieOverTemp(dieOverTemp), .drvOverTemp(drvOverTemp),
    .gateOn(gateOn), .opState(opState), .ohState(ohState));
